// ==== design/fpa_host.sv ====
/*
 * Host controller that drives an asynchronous parallel NOR flash through
 * its pins to read identifier codes, check and change group protection.
 * It assumes an APB master for software and a flash whose pin timing is
 * met by the cycle counts of the package.
 */
// Decided for this implementation: the address map and the APB slave port.
//
// Function
// - Protect check: group on top bits, 10.
// - Primary method: high voltage on reset.
// - Protect all groups before first unprotect.
// - Alternate method: high voltage A9 and OE.
`timescale 1ns/10ps
`default_nettype none
module fpa_host
  import fpa_pkg::*;
(
  input  wire logic              pclk,      // APB clock, 40 MHz
  input  wire logic              presetn,   // Asynchronous reset, low
  input  wire logic              clk_en,    // Freezes all state when low
  input  wire logic              psel,      // APB select
  input  wire logic              penable,   // APB enable
  input  wire logic              pwrite,    // APB direction
  input  wire logic [7:0]        paddr,     // APB byte address
  input  wire logic [31:0]       pwdata,    // APB write data
  output var  logic [31:0]       prdata,    // APB read data
  output var  logic              pready,    // APB ready
  output var  logic              pslverr,   // APB error, unmapped
  output var  fpa_pins_t         flash,     // Flash pin drive
  input  wire logic [FPA_DW-1:0] flash_dq_i // Flash data pins in
);

  // ************************************************************
  // State
  // ************************************************************
  typedef enum logic [2:0] {
    FPA_S_IDLE, FPA_S_SETUP, FPA_S_STROBE, FPA_S_HOLD
  } fpa_state_t;

  fpa_state_t         state;
  fpa_op_t            op;
  logic [FPA_AW-1:0]  addr_reg;
  logic [FPA_DW-1:0]  wdata_reg;
  logic [FPA_DW-1:0]  rdata_reg;
  logic [2:0]         pinctl;
  logic [FPA_NGRP-1:0] grpmap;
  logic               done;
  logic               refused;
  logic               prot_bit;
  logic               locked;
  logic               wp_high;
  logic [7:0]         cnt;
  logic [FPA_DW-1:0]  dq_s1;
  logic [FPA_DW-1:0]  dq_s2;
  logic [FPA_DW-1:0]  dq_s3;

  // ************************************************************
  // APB decode
  // ************************************************************
  wire        wr_en     = psel & penable & pready & pwrite;
  wire        setup     = psel & ~penable & ~pready;
  wire        hit_ctrl  = paddr == FPA_OFF_CTRL;
  wire        hit_addr  = paddr == FPA_OFF_ADDR;
  wire        hit_wdata = paddr == FPA_OFF_WDATA;
  wire        hit_rdata = paddr == FPA_OFF_RDATA;
  wire        hit_stat  = paddr == FPA_OFF_STATUS;
  wire        hit_pin   = paddr == FPA_OFF_PINCTL;
  wire        hit_grp   = paddr == FPA_OFF_GRPMAP;
  wire        mapped    = hit_ctrl | hit_addr | hit_wdata | hit_rdata
                        | hit_stat | hit_pin | hit_grp;
  wire        busy      = state != FPA_S_IDLE;
  wire [31:0] stat_word = {26'h0, wp_high, locked, prot_bit, refused,
                           done, busy};
  wire [31:0] next_rd   = hit_ctrl  ? {29'h0, op}
                        : hit_addr  ? {10'h0, addr_reg}
                        : hit_wdata ? {16'h0, wdata_reg}
                        : hit_rdata ? {16'h0, rdata_reg}
                        : hit_stat  ? stat_word
                        : hit_pin   ? {29'h0, pinctl}
                        : hit_grp   ? grpmap
                        : 32'h0000_0000;

  // ************************************************************
  // Operation start and refusal
  // ************************************************************
  wire       start     = wr_en & hit_ctrl & ~busy;
  wire [2:0] new_op    = pwdata[2:0];
  // Unprotecting while any group is still unprotected is refused.
  wire       bad_unp   = new_op == FPA_OP_UNPROT && grpmap != '1;
  // Plain cycles carry command writes and region reads.
  // Region entry and exit are such command writes too.
  wire       is_wr_op  = op != FPA_OP_READ && op != FPA_OP_ID_HV;
  wire       hv_a9     = op == FPA_OP_ID_HV || op == FPA_OP_ALT_PRT;
  // Primary method raises only the reset qualifier.
  wire       hv_rst_op = op == FPA_OP_UNPROT || op == FPA_OP_PROTECT;
  // A1 and A0 pick maker, device, group check or indicator.
  wire [1:0] id_sel    = addr_reg[FPA_A_SEL_HI:FPA_A_SEL_LO];
  // Five top bits pick one 128 Kword group.
  wire [4:0] grp_idx   = addr_reg[FPA_A_GRP_HI:FPA_A_GRP_LO];
  wire       dq_stable = dq_s2 == dq_s3;
  wire       strobe_end = is_wr_op ? cnt >= 8'(FPA_WP_CYC)
                        : (cnt >= 8'(FPA_ACC_CYC) && dq_stable);
  // High-voltage identifier read forces A6 low.
  wire [FPA_AW-1:0] pin_addr = hv_a9
                        ? (addr_reg & ~(22'h1 << FPA_A_MODE))
                        : addr_reg;
  // Upper byte of identifier codes is don't-care, kept as zero.
  wire [FPA_DW-1:0] cap_data = (op == FPA_OP_ID_HV)
                        ? {8'h00, dq_s3[7:0]} : dq_s3;

  // ************************************************************
  // Data pin synchroniser, three stages
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_s1 <= '0;
      dq_s2 <= '0;
      dq_s3 <= '0;
    end else if (clk_en) begin
      dq_s1 <= flash_dq_i;
      dq_s2 <= dq_s1;
      dq_s3 <= dq_s2;
    end
  end

  // ************************************************************
  // APB slave
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else if (clk_en) begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      prdata  <= setup ? next_rd : 32'h0000_0000;
    end
  end

  // ************************************************************
  // Software registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_reg  <= '0;
      wdata_reg <= '0;
      pinctl    <= FPA_PINCTL_RST;
    end else if (clk_en && wr_en && !busy) begin
      if (hit_addr)
        addr_reg <= pwdata[FPA_AW-1:0];
      if (hit_wdata)
        wdata_reg <= pwdata[FPA_DW-1:0];
      // Dropping the reset qualifier restores earlier protection.
      if (hit_pin)
        pinctl <= pwdata[2:0];
    end
  end

  // ************************************************************
  // Pin sequencer
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= FPA_S_IDLE;
      op        <= FPA_OP_READ;
      cnt       <= '0;
      rdata_reg <= '0;
      done      <= 1'b0;
      refused   <= 1'b0;
    end else if (clk_en) begin
      if (wr_en && hit_stat && pwdata[FPA_ST_DONE])
        done <= 1'b0;
      if (wr_en && hit_stat && pwdata[FPA_ST_REFUSED])
        refused <= 1'b0;
      unique case (state)
        FPA_S_IDLE: begin
          if (start && bad_unp) begin
            refused <= 1'b1;
          end else if (start) begin
            op    <= fpa_op_t'(new_op);
            state <= FPA_S_SETUP;
            cnt   <= '0;
          end
        end
        FPA_S_SETUP: begin
          state <= FPA_S_STROBE;
        end
        FPA_S_STROBE: begin
          cnt <= cnt + 8'h01;
          if (strobe_end) begin
            if (!is_wr_op)
              rdata_reg <= cap_data;
            state <= FPA_S_HOLD;
            cnt   <= '0;
          end
        end
        FPA_S_HOLD: begin
          cnt <= cnt + 8'h01;
          if (cnt >= 8'(FPA_HLD_CYC - 1)) begin
            state <= FPA_S_IDLE;
            done  <= 1'b1;
          end
        end
      endcase
    end
  end

  // ************************************************************
  // Decoding of identifier answers
  // ************************************************************
  wire id_end   = state == FPA_S_STROBE && strobe_end && op == FPA_OP_ID_HV;
  wire prot_rd  = id_end && id_sel == 2'b10;
  wire lock_rd  = id_end && id_sel == 2'b11;

  // Group map starts clear, as the part ships unprotected.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grpmap   <= FPA_GRPMAP_RST;
      prot_bit <= 1'b0;
      locked   <= 1'b0;
      wp_high  <= 1'b0;
    end else if (clk_en) begin
      // Protection answer is 01h protected, 00h not.
      // A set bit marks a group that refuses program and erase.
      if (prot_rd) begin
        prot_bit        <= dq_s3[0];
        grpmap[grp_idx] <= dq_s3[0];
      end
      // Bit 7 is the lock, bit 4 tells top from bottom.
      // Lock set: region read-only for good.
      if (lock_rd) begin
        locked  <= dq_s3[FPA_DQ_LOCK];
        wp_high <= dq_s3[FPA_DQ_WPTOP];
      end
    end
  end

  // ************************************************************
  // Flash pin drive
  // ************************************************************
  wire in_strobe = state == FPA_S_STROBE;
  wire active    = state != FPA_S_IDLE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b1,
                 wp_n: 1'b1, hv_reset: 1'b0, hv_addr_pin: 1'b0,
                 hv_oe: 1'b0, addr: '0, dq_o: '0, dq_oe: 1'b0};
    end else if (clk_en) begin
      flash.ce_n        <= ~active;
      flash.oe_n        <= ~(in_strobe & ~is_wr_op);
      flash.we_n        <= ~(in_strobe & is_wr_op);
      flash.addr        <= pin_addr;
      flash.dq_o        <= wdata_reg;
      flash.dq_oe       <= active & is_wr_op;
      // Software reset pulse returns the first sector to the array.
      flash.rst_n       <= pinctl[FPA_PC_RST];
      // Low write-protect keeps the edge sector locked.
      // High write-protect leaves stored protection in charge.
      flash.wp_n        <= pinctl[FPA_PC_WP];
      // Qualifiers are separate outputs, one per pin.
      flash.hv_reset    <= pinctl[FPA_PC_HVRST] | (active & hv_rst_op);
      flash.hv_addr_pin <= active & hv_a9;
      // Alternate programmer method adds OE qualifier.
      flash.hv_oe       <= active & op == FPA_OP_ALT_PRT;
    end
  end

endmodule
`default_nettype wire

// ==== design/fpa_pkg.sv ====
/*
 * Package for the flash identification and protection host controller.
 * It holds the register map, field positions, operation codes, timing
 * counts and the pin bundle. It assumes a 40 MHz pclk.
 */
package fpa_pkg;

  // ************************************************************
  // Register map: byte offsets on the APB bus
  // ************************************************************
  localparam logic [7:0] FPA_OFF_CTRL   = 8'h00;
  localparam logic [7:0] FPA_OFF_ADDR   = 8'h04;
  localparam logic [7:0] FPA_OFF_WDATA  = 8'h08;
  localparam logic [7:0] FPA_OFF_RDATA  = 8'h0C;
  localparam logic [7:0] FPA_OFF_STATUS = 8'h10;
  localparam logic [7:0] FPA_OFF_PINCTL = 8'h14;
  localparam logic [7:0] FPA_OFF_GRPMAP = 8'h18;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int FPA_ST_BUSY    = 0;
  localparam int FPA_ST_DONE    = 1;
  localparam int FPA_ST_REFUSED = 2;
  localparam int FPA_ST_PROT    = 3;
  localparam int FPA_ST_LOCKED  = 4;
  localparam int FPA_ST_WPHIGH  = 5;
  localparam int FPA_PC_WP      = 0;
  localparam int FPA_PC_HVRST   = 1;
  localparam int FPA_PC_RST     = 2;
  localparam int FPA_DQ_LOCK    = 7;
  localparam int FPA_DQ_WPTOP   = 4;
  localparam int FPA_A_SEL_LO   = 0;
  localparam int FPA_A_SEL_HI   = 1;
  localparam int FPA_A_MODE     = 6;
  localparam int FPA_A_GRP_LO   = 17;
  localparam int FPA_A_GRP_HI   = 21;

  // ************************************************************
  // Widths and reset values
  // ************************************************************
  localparam int FPA_AW     = 22;
  localparam int FPA_DW     = 16;
  localparam int FPA_NGRP   = 32;
  localparam logic [2:0] FPA_PINCTL_RST = 3'h5;
  localparam logic [FPA_NGRP-1:0] FPA_GRPMAP_RST = 32'h0000_0000;

  // ************************************************************
  // Timing, in nanoseconds and in pclk cycles
  // ************************************************************
  localparam int FPA_CLK_NS  = 25;
  localparam int FPA_ACC_NS  = 100;
  localparam int FPA_WP_NS   = 50;
  localparam int FPA_HOLD_NS = 25;
  localparam int FPA_ACC_CYC = (FPA_ACC_NS + FPA_CLK_NS - 1) / FPA_CLK_NS;
  localparam int FPA_WP_CYC  = (FPA_WP_NS + FPA_CLK_NS - 1) / FPA_CLK_NS;
  localparam int FPA_HLD_CYC = (FPA_HOLD_NS + FPA_CLK_NS - 1) / FPA_CLK_NS;

  // ************************************************************
  // Operations and pin bundle
  // ************************************************************
  typedef enum logic [2:0] {
    FPA_OP_READ    = 3'h0,
    FPA_OP_WRITE   = 3'h1,
    FPA_OP_ID_HV   = 3'h2,
    FPA_OP_ALT_PRT = 3'h3,
    FPA_OP_UNPROT  = 3'h4,
    FPA_OP_PROTECT = 3'h5
  } fpa_op_t;

  typedef struct packed {
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic              rst_n;
    logic              wp_n;
    logic              hv_reset;
    logic              hv_addr_pin;
    logic              hv_oe;
    logic [FPA_AW-1:0] addr;
    logic [FPA_DW-1:0] dq_o;
    logic              dq_oe;
  } fpa_pins_t;

endpackage

// ==== verification/fpa_flash_model.sv ====
/* Behavioural model of the flash identifier and group protection logic.
   Assumes the host drives the pin bundle of fpa_pkg. */
`timescale 1ns/10ps
`default_nettype none
module fpa_flash_model
  import fpa_pkg::*;
#(
  parameter logic [15:0] MAKER_CODE     = 16'h00A7, // Arbitrary value
  parameter logic [15:0] DEVICE_CODE    = 16'h5C3E, // Arbitrary value
  parameter bit          FACTORY_LOCKED = 1'b1,     // Region locked
  parameter bit          WP_GUARDS_TOP  = 1'b1      // Top sector guarded
)(
  input  wire fpa_pins_t         pins, // Pins from the host
  output logic [FPA_DW-1:0]      dq    // Data pins to the host
);
  // ************************************************************
  // Read path and protection state
  // ************************************************************
  logic [FPA_NGRP-1:0] prot = '0;
  logic [FPA_DW-1:0]   val;
  logic [FPA_DW-1:0]   last = '0;
  wire                 rd  = !pins.ce_n && !pins.oe_n;
  wire [4:0]           grp = pins.addr[FPA_A_GRP_HI:FPA_A_GRP_LO];
  wire [7:0]           ind = {FACTORY_LOCKED, 2'b00, WP_GUARDS_TOP, 4'h8};
  always_comb begin
    if (!pins.hv_addr_pin || pins.addr[FPA_A_MODE])
      val = pins.addr[15:0] ^ 16'h5A5A;
    else case (pins.addr[1:0])
      2'h0: val = MAKER_CODE;
      2'h1: val = DEVICE_CODE;
      2'h2: val = {15'h0000, prot[grp]};
      default: val = {8'h00, ind};
    endcase
  end
  always @* if (rd) last = val;
  // A released bus must not look like a held copy of the last word.
  assign dq = rd ? val : ~last;
  always @(posedge pins.we_n) begin
    if (!pins.ce_n && pins.hv_addr_pin && pins.hv_oe) prot[grp] <= 1'b1;
  end
endmodule
`default_nettype wire

// ==== verification/fpa_host_assertions.sv ====
/* Checker for the flash host controller: APB answer and flash pins.
   Assumes it is bound to fpa_host and that clk_en stays high. */
`timescale 1ns/10ps
`default_nettype none
module fpa_host_chk
  import fpa_pkg::*;
(
  input wire logic        pclk,      // Clock
  input wire logic        presetn,   // Reset, low
  input wire logic        clk_en,    // Run enable
  input wire logic        psel,      // APB select
  input wire logic        penable,   // APB enable
  input wire logic        pwrite,    // APB direction
  input wire logic [7:0]  paddr,     // APB address
  input wire logic [31:0] pwdata,    // APB write data
  input wire logic [31:0] prdata,    // APB read data
  input wire logic        pready,    // APB ready
  input wire logic        pslverr,   // APB error
  input wire fpa_pins_t   flash,     // Flash pins
  input wire logic [15:0] flash_dq_i // Flash data in
);
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable && clk_en;
  endsequence
  sequence s_one_ready;
    pready ##1 !pready;
  endsequence
  a_ready_once: assert property (s_setup |=> s_one_ready)
    else $error("pready not one cycle after setup");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_unmapped: assert property ((s_setup and paddr > 8'h18) |=> pslverr)
    else $error("unmapped access not flagged");
  a_read_select: assert property (!flash.oe_n |-> !flash.ce_n)
    else $error("output enable without chip enable");
  a_write_inhibit: assert property (!flash.we_n |-> flash.oe_n && flash.dq_oe)
    else $error("write strobe with output enable or no drive");
  a_read_pulse: assert property ($fell(flash.oe_n) |-> !flash.oe_n[*4])
    else $error("read strobe shorter than access time");
  a_write_pulse: assert property ($fell(flash.we_n) |-> !flash.we_n[*2])
    else $error("write strobe shorter than two cycles");
  a_alt_pair: assert property (flash.hv_oe |-> flash.hv_addr_pin)
    else $error("high voltage on enable alone");
  a_id_mode: assert property (flash.hv_addr_pin && !flash.oe_n |->
    !flash.addr[FPA_A_MODE]) else $error("identifier read with mode bit high");
endmodule
bind fpa_host fpa_host_chk fpa_host_chk_i (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash(flash),
  .flash_dq_i(flash_dq_i));
`default_nettype wire

// ==== verification/fpa_host_test.sv ====
/* Self-checking bench for the flash host controller.
   Assumes the flash model and the bound checker are compiled with it. */
`timescale 1ns/10ps
`default_nettype none
module fpa_host_test
  import fpa_pkg::*;
;
  // ************************************************************
  // Stimulus and instances
  // ************************************************************
  localparam logic [15:0] MAKER  = 16'h00A7; // Arbitrary value
  localparam logic [15:0] DEVICE = 16'h5C3E; // Arbitrary value
  logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, r, st;
  logic        pready, pslverr, err, hv_seen = 0;
  fpa_pins_t   flash;
  logic [15:0] flash_dq, dq_a, dq_b;
  logic        sel_b = 0;
  int          n_errors = 0, checks = 0, cyc = 0;
  fpa_host fpa_host_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash(flash), .flash_dq_i(flash_dq));
  fpa_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE))
    fpa_flash_model_i (.pins(flash), .dq(dq_a));
  // Second part: customer lockable, write-protect on the lowest sector.
  fpa_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE),
    .FACTORY_LOCKED(1'b0), .WP_GUARDS_TOP(1'b0))
    fpa_flash_model_b (.pins(flash), .dq(dq_b));
  assign flash_dq = sel_b ? dq_b : dq_a;
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (flash.hv_reset === 1'b1) hv_seen <= 1'b1;
    if (cyc == 20000) begin
      n_errors++;
      end_sim;
    end
  end
  // Read data is taken at the edge that ends the access, not before.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run_op(input logic [2:0] op, input logic [31:0] a);
    apb(1'b1, FPA_OFF_ADDR, a);
    apb(1'b1, FPA_OFF_CTRL, {29'h0, op});
    do apb(1'b0, FPA_OFF_STATUS, 32'h0); while (r[FPA_ST_DONE] !== 1'b1);
    st = r;
    apb(1'b1, FPA_OFF_STATUS, 32'h6);
    apb(1'b0, FPA_OFF_RDATA, 32'h0);
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset;
    apb(1'b0, FPA_OFF_PINCTL, 32'h0); chk(r, 32'h5);
    apb(1'b0, FPA_OFF_GRPMAP, 32'h0); chk(r, 32'h0);
    apb(1'b0, 8'h1C, 32'h0); chk({31'h0, err}, 32'h1);
  endtask
  task automatic t_ident;
    logic [31:0] exp [4];
    // Identifier answers keep only the low byte.
    exp = '{{24'h0, MAKER[7:0]}, {24'h0, DEVICE[7:0]}, 32'h0, 32'h98};
    for (int s = 0; s < 4; s++) begin
      run_op(FPA_OP_ID_HV, s);
      chk(r, exp[s]);
    end
    chk({30'h0, st[FPA_ST_WPHIGH:FPA_ST_LOCKED]}, 32'h3);
    sel_b <= 1'b1;
    run_op(FPA_OP_ID_HV, 32'h3);
    chk(r, 32'h08);
    chk({30'h0, st[FPA_ST_WPHIGH:FPA_ST_LOCKED]}, 32'h0);
    sel_b <= 1'b0;
  endtask
  task automatic t_protect;
    run_op(FPA_OP_ID_HV, 32'h000A_0002); chk(r, 32'h0);
    run_op(FPA_OP_ALT_PRT, 32'h000A_0000);
    run_op(FPA_OP_ID_HV, 32'h000A_0002); chk(r, 32'h1);
    chk({31'h0, st[FPA_ST_PROT]}, 32'h1);
    run_op(FPA_OP_ID_HV, 32'h0008_0002); chk(r, 32'h0);
    apb(1'b0, FPA_OFF_GRPMAP, 32'h0); chk(r, 32'h0000_0020);
  endtask
  task automatic t_refuse;
    apb(1'b1, FPA_OFF_CTRL, {29'h0, FPA_OP_UNPROT});
    do apb(1'b0, FPA_OFF_STATUS, 32'h0); while (r[2:1] === 2'b00);
    chk({31'h0, r[FPA_ST_REFUSED]}, 32'h1);
    chk({31'h0, hv_seen}, 32'h0);
    apb(1'b1, FPA_OFF_STATUS, 32'h6);
    run_op(FPA_OP_PROTECT, 32'h0000_0000);
    chk({31'h0, hv_seen}, 32'h1);
    chk({31'h0, flash.hv_reset}, 32'h0);
  endtask
  task automatic t_array;
    run_op(FPA_OP_READ, 32'h0000_1234);
    chk(r, {16'h0, 16'h1234 ^ 16'h5A5A});
    apb(1'b1, FPA_OFF_PINCTL, 32'h4);
    repeat (2) @(negedge pclk);
    chk({31'h0, flash.wp_n}, 32'h0);
    apb(1'b1, FPA_OFF_PINCTL, 32'h5);
    repeat (2) @(negedge pclk);
    chk({31'h0, flash.wp_n}, 32'h1);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_ident;
    t_protect;
    t_refuse;
    t_array;
    end_sim;
  end
endmodule
`default_nettype wire
